// *** loader_cfg.svh ***
// Operation
// - copy ids and subsystem ids from words
// - word 06h bit0 sets vc count
// - word 06h bits3:1 set l0s latency
// - word 06h bits6:4 set l1 latency
// - word 06h bit8 sets egress unordered
// - word 06h bit9 sets tag unordered
// - word 06h bit10 selects store-forward
// - word 06h bits12:11 set threshold
// - bits13,14 set arbiter and credit modes
// - word 06h bit15 sets inta, ports 1-2
// - word 0Ch bits1:0 set max payload
// - word 0Ch bits3:2 set aspm support
// - word 0Ch bit4 sets role error reporting
// - word 0Ch bit5 disables msi
// - word 0Ch bit6 disables compliance parity
// - word 0Ch bit7 disables power management
// - word 0Ch bit8 enables posted passing
// - word 0Ch bit9 sets bandwidth notify, ports 1-2
// - word 0Ch bit10 freezes ordering
`ifndef LOADER_CFG_SVH
`define LOADER_CFG_SVH
`define ROM_SIG_ADDR 8'h00
`define ROM_VID_ADDR 8'h02
`define ROM_DID_ADDR 8'h04
`define ROM_MODE_ADDR 8'h06
`define ROM_SVID_ADDR 8'h08
`define ROM_SSID_ADDR 8'h0A
`define ROM_CAP_ADDR 8'h0C
`define ROM_SIGNATURE 16'h5A5A
`define CFG_INTPIN_OFS 12'h03C
`define CFG_CAPDIS_OFS 12'h070
`define CFG_SWMODE_OFS 12'h074
`define CFG_ORDER_OFS 12'h08C
`define CFG_DEVCAP_OFS 12'h0C4
`define CFG_LINKCAP_OFS 12'h0CC
`define CFG_VC_OFS 12'h144
`define CFG_ID_OFS 12'h000
`define CFG_SUBID_OFS 12'h0B4
`define DEF_VID 16'h0000
`define DEF_DID 16'h0000
`define DEF_MODE 16'h0000
`define DEF_CAP 16'h0000
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define REG_VID 4'h8
`define REG_SVID 4'hC
`define STAT_DONE_BIT 0
`define STAT_SIGOK_BIT 1
`endif

// *** loader_pkg.sv ***
package loader_pkg;
    typedef enum logic [2:0] {
        ST_IDLE, ST_REQ, ST_WAIT, ST_NEXT, ST_DONE
    } load_state_t;
    typedef struct packed {
        logic [15:0] vendor_id;
        logic [15:0] device_id;
        logic [15:0] subsys_vendor_id;
        logic [15:0] subsys_id;
        logic [15:0] mode_word;
        logic [15:0] cap_word;
    } rom_image_t;
    typedef struct packed {
        logic [2:0][31:0] vc_reg;
        logic [2:0][31:0] link_cap;
        logic [2:0][31:0] sw_mode;
        logic [2:0][31:0] int_pin;
        logic [2:0][31:0] dev_cap;
        logic [2:0][31:0] cap_dis;
        logic [2:0][31:0] order;
    } port_cfg_t;
endpackage : loader_pkg

// *** cfg_field_map.sv ***
`timescale 1ns/1ps
`include "loader_cfg.svh"
module cfg_field_map (
    // loaded image
    input loader_pkg::rom_image_t image_i,
    // per-port register fields
    output loader_pkg::port_cfg_t cfg_o
);
    import loader_pkg::*;
    always_comb begin
        cfg_o = '0;
        for (int p = 0; p < 3; p++) begin
            cfg_o.vc_reg[p][0] = image_i.mode_word[0];
            cfg_o.link_cap[p][14:12] = image_i.mode_word[3:1];
            cfg_o.link_cap[p][17:15] = image_i.mode_word[6:4];
            cfg_o.sw_mode[p][5] = image_i.mode_word[8];
            cfg_o.sw_mode[p][6] = image_i.mode_word[9];
            cfg_o.sw_mode[p][0] = image_i.mode_word[10];
            cfg_o.sw_mode[p][2:1] = image_i.mode_word[12:11];
            cfg_o.sw_mode[p][3] = image_i.mode_word[13];
            cfg_o.sw_mode[p][4] = image_i.mode_word[14];
            if (p != 0) begin
                cfg_o.int_pin[p][8] = image_i.mode_word[15];
                cfg_o.link_cap[p][21] = image_i.cap_word[9];
            end
            cfg_o.dev_cap[p][1:0] = image_i.cap_word[1:0];
            cfg_o.link_cap[p][11:10] = image_i.cap_word[3:2];
            cfg_o.dev_cap[p][15] = image_i.cap_word[4];
            cfg_o.cap_dis[p][14] = image_i.cap_word[5];
            cfg_o.sw_mode[p][15] = image_i.cap_word[6];
            cfg_o.cap_dis[p][13] = image_i.cap_word[7];
            cfg_o.order[p][5] = image_i.cap_word[8];
            cfg_o.order[p][6] = image_i.cap_word[10];
        end
    end
endmodule : cfg_field_map

// *** rom_loader.sv ***
// The placing of the registers and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ps
`include "loader_cfg.svh"
module rom_loader (
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // serial memory word reader
    output logic rom_req_o,
    output logic [7:0] rom_addr_o,
    input wire logic rom_ack_i,
    input wire logic [15:0] rom_data_i,
    // configuration access from link
    input wire logic cfg_req_i,
    input wire logic [11:0] cfg_addr_i,
    input wire logic [1:0] cfg_port_i,
    output logic cfg_ack_o,
    output logic cfg_retry_o,
    output logic [31:0] cfg_rdata_o,
    // avalon-mm slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // status
    output logic load_done_o
);
    import loader_pkg::*;

    load_state_t state_q;
    rom_image_t image_q;
    port_cfg_t cfg_w;
    logic sig_ok_q;
    logic [2:0] idx_q;
    logic reload_q;

    function automatic logic [7:0] word_addr(input logic [2:0] idx);
        case (idx)
            3'd0: word_addr = `ROM_SIG_ADDR;
            3'd1: word_addr = `ROM_VID_ADDR;
            3'd2: word_addr = `ROM_DID_ADDR;
            3'd3: word_addr = `ROM_MODE_ADDR;
            3'd4: word_addr = `ROM_SVID_ADDR;
            3'd5: word_addr = `ROM_SSID_ADDR;
            default: word_addr = `ROM_CAP_ADDR;
        endcase
    endfunction : word_addr

    function automatic logic [31:0] sel_port(input logic [2:0][31:0] r, input logic [1:0] p);
        sel_port = (p == 2'd3) ? 32'h0000_0000 : r[p];
    endfunction : sel_port

    cfg_field_map u_map (
        .image_i(image_q),
        .cfg_o(cfg_w)
    );

    // load sequencer
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            state_q <= ST_IDLE;
            idx_q <= 3'd0;
            rom_req_o <= 1'b0;
            rom_addr_o <= 8'h00;
            load_done_o <= 1'b0;
            sig_ok_q <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    idx_q <= 3'd0;
                    load_done_o <= 1'b0;
                    sig_ok_q <= 1'b0;
                    state_q <= ST_REQ;
                end
                ST_REQ: begin
                    rom_req_o <= 1'b1;
                    rom_addr_o <= word_addr(idx_q);
                    state_q <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (rom_ack_i) begin
                        rom_req_o <= 1'b0;
                        state_q <= ST_NEXT;
                        if (idx_q == 3'd0) begin
                            sig_ok_q <= (rom_data_i == `ROM_SIGNATURE);
                        end
                    end
                end
                ST_NEXT: begin
                    if (!sig_ok_q || idx_q == 3'd6) begin
                        state_q <= ST_DONE;
                    end else begin
                        idx_q <= idx_q + 3'd1;
                        state_q <= ST_REQ;
                    end
                end
                ST_DONE: begin
                    load_done_o <= 1'b1;
                    if (reload_q) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // image capture
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            image_q <= '{`DEF_VID, `DEF_DID, 16'h0000, 16'h0000, `DEF_MODE, `DEF_CAP};
        end else if (state_q == ST_WAIT && rom_ack_i && sig_ok_q) begin
            case (idx_q)
                3'd1: image_q.vendor_id <= rom_data_i;
                3'd2: image_q.device_id <= rom_data_i;
                3'd3: image_q.mode_word <= rom_data_i;
                3'd4: image_q.subsys_vendor_id <= rom_data_i;
                3'd5: image_q.subsys_id <= rom_data_i;
                3'd6: image_q.cap_word <= rom_data_i;
                default: image_q <= image_q;
            endcase
        end
    end

    // configuration read port
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            cfg_ack_o <= 1'b0;
            cfg_retry_o <= 1'b0;
            cfg_rdata_o <= 32'h0000_0000;
        end else begin
            cfg_ack_o <= cfg_req_i && load_done_o;
            cfg_retry_o <= cfg_req_i && !load_done_o;
            if (cfg_req_i && load_done_o) begin
                case (cfg_addr_i)
                    `CFG_ID_OFS: cfg_rdata_o <= {image_q.device_id, image_q.vendor_id};
                    `CFG_SUBID_OFS: cfg_rdata_o <= {image_q.subsys_id, image_q.subsys_vendor_id};
                    `CFG_INTPIN_OFS: cfg_rdata_o <= sel_port(cfg_w.int_pin, cfg_port_i);
                    `CFG_CAPDIS_OFS: cfg_rdata_o <= sel_port(cfg_w.cap_dis, cfg_port_i);
                    `CFG_SWMODE_OFS: cfg_rdata_o <= sel_port(cfg_w.sw_mode, cfg_port_i);
                    `CFG_ORDER_OFS: cfg_rdata_o <= sel_port(cfg_w.order, cfg_port_i);
                    `CFG_DEVCAP_OFS: cfg_rdata_o <= sel_port(cfg_w.dev_cap, cfg_port_i);
                    `CFG_LINKCAP_OFS: cfg_rdata_o <= sel_port(cfg_w.link_cap, cfg_port_i);
                    `CFG_VC_OFS: cfg_rdata_o <= sel_port(cfg_w.vc_reg, cfg_port_i);
                    default: cfg_rdata_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // avalon slave, one wait cycle per access
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
            reload_q <= 1'b0;
        end else begin
            reload_q <= 1'b0;
            // high while idle, low only for the edge that completes an access
            avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
            // write lands only at the edge where waitrequest is low
            if (avs_write && !avs_waitrequest && avs_address == `REG_CTRL) begin
                reload_q <= avs_writedata[0];
            end
            // read data loaded on the wait edge, stands at the completing edge
            if (avs_read && avs_waitrequest) begin
                case (avs_address)
                    `REG_STATUS: avs_readdata <= {30'h0000_0000, sig_ok_q, load_done_o};
                    `REG_VID: avs_readdata <= {image_q.device_id, image_q.vendor_id};
                    `REG_SVID: avs_readdata <= {image_q.subsys_id, image_q.subsys_vendor_id};
                    default: avs_readdata <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule : rom_loader

// *** rom_model.sv ***
`timescale 1ns/1ps
module rom_model (
    // clock
    input wire logic clk_i,
    // word reader
    input wire logic rom_req_i,
    input wire logic [7:0] rom_addr_i,
    output logic rom_ack_o,
    output logic [15:0] rom_data_o,
    // contents and answer delay
    input wire logic [6:0][15:0] words_i,
    input wire logic [3:0] delay_i
);
    logic [3:0] wait_q = 4'h0;
    initial rom_ack_o = 1'b0;
    initial rom_data_o = 16'h0000;
    always @(posedge clk_i) begin
        if (rom_req_i && !rom_ack_o && wait_q >= delay_i) begin
            rom_ack_o <= 1'b1;
            rom_data_o <= words_i[rom_addr_i[3:1]];
            wait_q <= 4'h0;
        end else begin
            // data line keeps changing between words
            rom_ack_o <= 1'b0;
            rom_data_o <= ~rom_data_o;
            wait_q <= (rom_req_i && !rom_ack_o) ? wait_q + 4'h1 : 4'h0;
        end
    end
endmodule : rom_model

// *** rom_loader_assertions.sv ***
`timescale 1ns/1ps
module rom_loader_assertions (
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // memory side
    input wire logic rom_req_o,
    input wire logic [7:0] rom_addr_o,
    input wire logic rom_ack_i,
    // config side
    input wire logic cfg_req_i,
    input wire logic [11:0] cfg_addr_i,
    input wire logic [1:0] cfg_port_i,
    input wire logic cfg_ack_o,
    input wire logic cfg_retry_o,
    input wire logic [31:0] cfg_rdata_o,
    input wire logic load_done_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);
    a_rom_req_hold: assert property (rom_req_o && !rom_ack_i |=> rom_req_o && $stable(rom_addr_o))
        else $error("memory request dropped early");
    a_sig_first: assert property ($rose(resetn_i) |-> ##[1:3] (rom_req_o && rom_addr_o == 8'h00))
        else $error("first word not signature");
    a_load_finish: assert property (rom_req_o && rom_ack_i && rom_addr_o == 8'h0C |-> ##[1:3] load_done_o)
        else $error("load not done after last word");
    a_cfg_retry: assert property (cfg_req_i && !load_done_o |=> cfg_retry_o && !cfg_ack_o)
        else $error("config access not retried");
    a_cfg_answer: assert property (cfg_req_i && load_done_o |=> cfg_ack_o && !cfg_retry_o)
        else $error("config access not answered");
    a_cfg_quiet: assert property (!cfg_req_i |=> !cfg_ack_o && !cfg_retry_o)
        else $error("config answer without request");
    a_swmode_bits: assert property (cfg_req_i && load_done_o && cfg_addr_i == 12'h074
        |=> cfg_rdata_o[31:16] == 16'h0000 && cfg_rdata_o[14:7] == 8'h00)
        else $error("switch mode stray bits");
    a_intpin_p0: assert property (cfg_req_i && load_done_o && cfg_addr_i == 12'h03C
        && cfg_port_i == 2'h0 |=> cfg_rdata_o == 32'h0000_0000)
        else $error("port 0 interrupt pin set");
endmodule : rom_loader_assertions
bind rom_loader rom_loader_assertions rom_loader_assertions_inst (.clk_i(clk_i),
    .resetn_i(resetn_i), .rom_req_o(rom_req_o), .rom_addr_o(rom_addr_o), .rom_ack_i(rom_ack_i),
    .cfg_req_i(cfg_req_i), .cfg_addr_i(cfg_addr_i), .cfg_port_i(cfg_port_i),
    .cfg_ack_o(cfg_ack_o), .cfg_retry_o(cfg_retry_o), .cfg_rdata_o(cfg_rdata_o),
    .load_done_o(load_done_o));

// *** rom_loader_tb_top.sv ***
`timescale 1ns/1ps
`include "loader_cfg.svh"
module rom_loader_tb_top;
    import loader_pkg::*;
    logic clk_i = 1'b0, resetn_i = 1'b0, cfg_req_i = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic [11:0] cfg_addr_i = 12'h000;
    logic [1:0] cfg_port_i = 2'h0;
    logic [3:0] avs_address = 4'h0, rom_delay = 4'h0;
    logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, cfg_rdata_o, rd;
    logic rom_req_o, rom_ack_i, cfg_ack_o, cfg_retry_o, avs_waitrequest, load_done_o, ack_q, rty_q;
    logic [7:0] rom_addr_o;
    logic [15:0] rom_data_i;
    logic [6:0][15:0] words;
    int err_total = 0, comparisons = 0;
    rom_loader rom_loader_inst (.clk_i, .resetn_i, .rom_req_o, .rom_addr_o, .rom_ack_i,
        .rom_data_i, .cfg_req_i, .cfg_addr_i, .cfg_port_i, .cfg_ack_o, .cfg_retry_o,
        .cfg_rdata_o, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
        .avs_waitrequest, .load_done_o);
    rom_model rom_model_inst (.clk_i, .rom_req_i(rom_req_o), .rom_addr_i(rom_addr_o),
        .rom_ack_o(rom_ack_i), .rom_data_o(rom_data_i), .words_i(words), .delay_i(rom_delay));
    initial begin
        forever #12.5 clk_i = ~clk_i;
    end
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wait_for(input logic lvl, input int lim);
        int n;
        n = 0;
        while (load_done_o !== lvl && n < lim) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= lim) begin
            err_total++;
            tally_and_finish();
        end
    endtask : wait_for
    task automatic avs(input logic wr, input logic [3:0] a, input logic [31:0] wd);
        int n;
        avs_address <= a;
        avs_read <= !wr;
        avs_write <= wr;
        avs_writedata <= wd;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 50) begin
            err_total++;
            tally_and_finish();
        end
        @(posedge clk_i);
    endtask : avs
    task automatic cfg_rd(input logic [11:0] o, input logic [1:0] p);
        cfg_req_i <= 1'b1;
        cfg_addr_i <= o;
        cfg_port_i <= p;
        @(posedge clk_i);
        cfg_req_i <= 1'b0;
        #1;
        {ack_q, rty_q, rd} = {cfg_ack_o, cfg_retry_o, cfg_rdata_o};
        @(posedge clk_i);
    endtask : cfg_rd
    task automatic cfg_chk(input logic [11:0] o, input logic [1:0] p, input logic [31:0] e);
        cfg_rd(o, p);
        check("cfg answer", {30'h0000_0000, rty_q, ack_q}, 32'h0000_0001);
        check("cfg data", rd, (p == 2'h3 && o != 12'h000 && o != 12'h0B4) ? 32'h0000_0000 : e);
    endtask : cfg_chk
    task automatic verify(input logic [15:0] x, input logic ok);
        logic [15:0] m, c, v, d, sv, si;
        {v, d, m, sv, si} = ok ? {16'h1234, 16'h5678, 16'hA5C3, 16'h9ABC, 16'hDEF0} ^ {5{x}} : 0;
        c = ok ? 16'h0555 ^ x : 16'h0000;
        avs(1'b0, `REG_STATUS, 32'h0000_0000);
        check("status", rd, {30'h0000_0000, ok, 1'b1});
        avs(1'b0, 4'h2, 32'h0000_0000);
        check("unmapped", rd, 32'h0000_0000);
        avs(1'b0, `REG_VID, 32'h0000_0000);
        check("ids", rd, {d, v});
        avs(1'b0, `REG_SVID, 32'h0000_0000);
        check("subsys ids", rd, {si, sv});
        cfg_chk(12'h000, 2'h0, {d, v});
        cfg_chk(12'h0B4, 2'h0, {si, sv});
        for (int p = 0; p < 4; p++) begin
            cfg_chk(12'h144, p[1:0], {31'h0000_0000, m[0]});
            cfg_chk(12'h0CC, p[1:0], {10'h000, c[9] && p != 0, 3'h0, m[6:1], c[3:2], 10'h000});
            cfg_chk(12'h074, p[1:0], {16'h0000, c[6], 8'h00, m[9:8], m[14:11], m[10]});
            cfg_chk(12'h03C, p[1:0], {23'h00_0000, m[15] && p != 0, 8'h00});
            cfg_chk(12'h0C4, p[1:0], {16'h0000, c[4], 13'h0000, c[1:0]});
            cfg_chk(12'h070, p[1:0], {17'h0_0000, c[5], c[7], 13'h0000});
            cfg_chk(12'h08C, p[1:0], {25'h000_0000, c[10], c[8], 5'h00});
        end
    endtask : verify
    initial begin
        words = {16'h0555, 16'hDEF0, 16'h9ABC, 16'hA5C3, 16'h5678, 16'h1234, `ROM_SIGNATURE};
        repeat (6) @(posedge clk_i);
        resetn_i <= 1'b1;
        @(posedge clk_i);
        cfg_rd(12'h000, 2'h0);
        check("early retry", {30'h0000_0000, rty_q, ack_q}, 32'h0000_0002);
        wait_for(1'b1, 2000);
        verify(16'h0000, 1'b1);
        words = {words[6:1] ^ {6{16'hFFFF}}, `ROM_SIGNATURE};
        rom_delay <= 4'h5;
        avs(1'b1, `REG_CTRL, 32'h0000_0001);
        wait_for(1'b0, 20);
        cfg_rd(12'h074, 2'h1);
        check("reload retry", {30'h0000_0000, rty_q, ack_q}, 32'h0000_0002);
        wait_for(1'b1, 2000);
        verify(16'hFFFF, 1'b1);
        words[0] = 16'h0000;
        resetn_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        resetn_i <= 1'b1;
        @(posedge clk_i);
        wait_for(1'b1, 2000);
        verify(16'h0000, 1'b0);
        tally_and_finish();
    end
endmodule : rom_loader_tb_top
